/* File: test/flash_device_model.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_device_model (
   input  wire logic       ce_n,
   input  wire logic       oe_n,
   input  wire logic       we_n,
   input  wire logic [7:0] dq_out,
   input  wire logic       dq_oe,
   output logic [7:0]      dq_in,
   output logic            ready_busy_n_pin
);
   logic       active = 1'b0;
   logic       fail   = 1'b0;
   logic       erase  = 1'b0;
   logic       prot   = 1'b0;
   logic       tog1   = 1'b0;
   logic       tog2   = 1'b0;
   logic [7:0] arr    = 8'hA5;
   logic [7:0] pd     = 8'h00;
   logic [7:0] last   = 8'h00;
   logic [7:0] wd     = 8'h00;
   logic [7:0] st;
   logic [7:0] val;
   int         cnt    = 0;
   wire        rd     = !ce_n && !oe_n;
   wire        wr     = !ce_n && !we_n && dq_oe;

   //==========================================================================
   // Command side
   //==========================================================================
   // status set by the testbench launch call, not by a write
   task automatic launch(input logic [7:0] d, input logic er,
                         input logic pr, input logic fl, input int n);
      pd = d;
      erase = er;
      prot = pr;
      fail = fl;
      cnt = n;
      active = 1'b1;
   endtask

   always @(dq_out or wr) if (wr) wd = dq_out;

   always @(negedge wr) begin
      if (wd == flash_status_pkg::CMD_RESET) begin
         active = 1'b0;
         fail = 1'b0;
      end
   end

   //==========================================================================
   // Status byte and read data
   //==========================================================================
   always_comb begin
      st = 8'h00;
      st[7] = erase ? (cnt == 0) : (pd[7] ^ (cnt != 0));
      st[6] = tog1;
      st[5] = fail;
      st[2] = tog2;
      val = active ? st : arr;
   end

   // Released bus shows the inverse of the last byte
   assign dq_in = rd ? val : ~last;

   assign ready_busy_n_pin = !(active && cnt != 0);

   //==========================================================================
   // Read end: advance the algorithm
   //==========================================================================
   always @(negedge rd) begin
      last = val;
      // true bit seen before the rest
      if (active && cnt == 0 && !fail) begin
         active = 1'b0;
         if (!prot) arr = erase ? 8'hFF : pd;
      end else if (active) begin
         // toggle per read, stops when done
         tog1 = !tog1;
         if (erase) tog2 = !tog2;
         if (cnt > 0 && !fail) cnt = cnt - 1;
      end
   end
endmodule // flash_device_model
`default_nettype wire

/* File: test/test_flash_status_poller.sv */
`timescale 1ns/10ps
`default_nettype none
module test_flash_status_poller;
   typedef struct packed {
      logic       meth;
      logic [7:0] d;
      logic       er;
      logic       pr;
      logic       fl;
      logic       ab;
      logic       ld;
      logic [7:0] n;
      logic [1:0] res;
      logic [7:0] fin;
   } row_t;
   localparam logic [1:0] R_OK = flash_status_pkg::RES_DONE;
   localparam logic [1:0] R_FL = flash_status_pkg::RES_FAIL;
   localparam logic [1:0] R_AB = flash_status_pkg::RES_ABORTED;

   logic       mclk = 1'b0;
   logic       rstn = 1'b0;
   logic       start = 1'b0;
   logic       method_toggle = 1'b0;
   logic       abort = 1'b0;
   logic [7:0] expect_data = 8'h00;
   logic       busy, done, device_busy, ce_n, oe_n, we_n, dq_oe, rbn;
   logic [1:0] result;
   logic [7:0] final_data, dq_out, dq_in;
   int         n_fail = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         k;
   row_t       r;
   row_t       tbl [9] = '{
      '{1'b0, 8'h5A, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h03, R_OK, 8'h5A},
      '{1'b1, 8'h3C, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h02, R_OK, 8'h3C},
      '{1'b0, 8'hFF, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h04, R_OK, 8'hFF},
      '{1'b1, 8'hFF, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01, R_OK, 8'hFF},
      '{1'b0, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h01, R_OK, 8'hFF},
      '{1'b0, 8'h81, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h05, R_FL, 8'h00},
      '{1'b1, 8'h81, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h05, R_FL, 8'h00},
      '{1'b1, 8'hFF, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h28, R_AB, 8'h00},
      '{1'b1, 8'hFF, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, R_OK, 8'hFF}};

   always #5 mclk = ~mclk;

   flash_status_poller uut (
      .mclk             (mclk),
      .rstn             (rstn),
      .start            (start),
      .method_toggle    (method_toggle),
      .expect_data      (expect_data),
      .abort            (abort),
      .busy             (busy),
      .done             (done),
      .result           (result),
      .final_data       (final_data),
      .device_busy      (device_busy),
      .ce_n             (ce_n),
      .oe_n             (oe_n),
      .we_n             (we_n),
      .dq_out           (dq_out),
      .dq_oe            (dq_oe),
      .dq_in            (dq_in),
      .ready_busy_n_pin (rbn)
   );

   flash_device_model dev (
      .ce_n             (ce_n),
      .oe_n             (oe_n),
      .we_n             (we_n),
      .dq_out           (dq_out),
      .dq_oe            (dq_oe),
      .dq_in            (dq_in),
      .ready_busy_n_pin (rbn)
   );

   //==========================================================================
   // Checking and closing
   //==========================================================================
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d, mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_fail++;
         close_out();
      end
   end

   //==========================================================================
   // Poll sequences
   //==========================================================================
   initial begin
      repeat (20) @(negedge mclk);
      rstn = 1'b1;
      @(negedge mclk);
      for (int i = 0; i < 9; i++) begin
         r = tbl[i];
         if (r.ld) dev.launch(r.d, r.er, r.pr, r.fl, int'(r.n));
         repeat (6) @(negedge mclk);
         check(8'(device_busy), 8'h01, "busy before poll");
         method_toggle = r.meth;
         expect_data = r.er ? 8'hFF : r.d;
         abort = r.ab;
         start = 1'b1;
         @(negedge mclk);
         start = 1'b0;
         k = 0;
         while (done !== 1'b1 && k < 2000) begin
            @(negedge mclk);
            k++;
         end
         abort = 1'b0;
         check(8'(k < 2000), 8'h01, "poll finished");
         check(8'(busy), 8'h00, "idle at done");
         check(8'(result), 8'(r.res), "result");
         if (r.res == R_OK) check(final_data, r.fin, "final data");
         repeat (6) @(negedge mclk);
         check(8'(device_busy), 8'(r.ab), "busy after poll");
         check(8'(dev.active), 8'(r.ab), "array mode");
      end
      close_out();
   end
endmodule // test_flash_status_poller
`default_nettype wire

/* File: verilog/flash_bus_cycle.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle (
   input  wire logic        mclk,
   input  wire logic        rstn,
   flash_cycle_if.slave     cyc,
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic [7:0]       dq_out,
   output logic             dq_oe,
   input  wire logic [7:0]  dq_in
);

   //==========================================================================
   // One asynchronous read or write cycle
   //==========================================================================
   typedef enum logic [1:0] {IDLE, STROBE, GAP} cyc_st_t;

   cyc_st_t                          st_r, st_nxt;
   logic [flash_status_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic                             wr_r, wr_nxt;
   logic [7:0]                       wd_r, wd_nxt;
   logic [7:0]                       rd_r, rd_nxt;
   logic                             done_r, done_nxt;

   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      wr_nxt   = wr_r;
      wd_nxt   = wd_r;
      rd_nxt   = rd_r;
      done_nxt = 1'b0;
      unique case (st_r)
         IDLE: begin
            if (cyc.req) begin
               st_nxt  = STROBE;
               wr_nxt  = cyc.wr;
               wd_nxt  = cyc.wdata;
               cnt_nxt = cyc.wr ?
                  flash_status_pkg::CNT_W'(flash_status_pkg::WE_PULSE_CYC) :
                  flash_status_pkg::CNT_W'(flash_status_pkg::ACCESS_CYC);
            end
         end
         STROBE: begin
            if (cnt_r == 1) begin
               // Data sampled at end of access, before strobe release
               rd_nxt  = dq_in;
               st_nxt  = GAP;
               cnt_nxt = flash_status_pkg::CNT_W'(flash_status_pkg::GAP_CYC);
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         GAP: begin
            if (cnt_r == 1) begin
               st_nxt   = IDLE;
               done_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_r   <= IDLE;
         cnt_r  <= '0;
         wr_r   <= 1'b0;
         wd_r   <= 8'h00;
         rd_r   <= 8'h00;
         done_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         wr_r   <= wr_nxt;
         wd_r   <= wd_nxt;
         rd_r   <= rd_nxt;
         done_r <= done_nxt;
      end
   end

   // Each cycle is framed by chip select so toggle bits advance per read
   assign ce_n      = !(st_r == STROBE);
   assign oe_n      = !(st_r == STROBE && !wr_r);
   assign we_n      = !(st_r == STROBE && wr_r);
   assign dq_oe     = (st_r != IDLE) && wr_r;
   assign dq_out    = wd_r;
   assign cyc.done  = done_r;
   assign cyc.rdata = rd_r;

endmodule : flash_bus_cycle
`default_nettype wire

/* File: verilog/flash_cycle_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface flash_cycle_if;
   logic       req;
   logic       wr;
   logic [7:0] wdata;
   logic       done;
   logic [7:0] rdata;

   modport master (output req, output wr, output wdata,
                   input done, input rdata);
   modport slave  (input req, input wr, input wdata,
                   output done, output rdata);
endinterface : flash_cycle_if
`default_nettype wire

/* File: verilog/flash_status_pkg.sv */
package flash_status_pkg;

   //==========================================================================
   // Data and command constants
   //==========================================================================
   localparam logic [7:0] CMD_RESET        = 8'hF0;
   localparam int         POLL_BIT         = 7;
   localparam int         TOGGLE_ONE_BIT   = 6;
   localparam int         TIMEOUT_BIT      = 5;
   localparam int         TOGGLE_TWO_BIT   = 2;

   //==========================================================================
   // Bus cycle timing
   //==========================================================================
   localparam int         CLK_PERIOD_NS    = 10;
   localparam int         ACCESS_NS        = 70;
   localparam int         ACCESS_CYC       =
      (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         WE_PULSE_NS      = 50;
   localparam int         WE_PULSE_CYC     =
      (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         GAP_NS           = 30;
   localparam int         GAP_CYC          =
      (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         CNT_W            = 4;

   //==========================================================================
   // Poll outcome codes and check methods
   //==========================================================================
   typedef enum logic [1:0] {
      RES_DONE    = 2'h0,
      RES_FAIL    = 2'h1,
      RES_ABORTED = 2'h2
   } result_t;

   typedef enum logic {
      METHOD_POLL_BIT,
      METHOD_TOGGLE
   } method_t;

endpackage : flash_status_pkg

/* File: verilog/flash_status_poller.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_status_poller (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        start,
   input  wire logic        method_toggle,
   input  wire logic [7:0]  expect_data,
   input  wire logic        abort,
   output logic             busy,
   output logic             done,
   output logic [1:0]       result,
   output logic [7:0]       final_data,
   output logic             device_busy,
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic [7:0]       dq_out,
   output logic             dq_oe,
   input  wire logic [7:0]  dq_in,
   input  wire logic        ready_busy_n_pin
);

   //==========================================================================
   // Ready/busy pin synchroniser
   //==========================================================================
   logic [2:0] rb_sync_r;
   logic       rb_level_r;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rb_sync_r  <= 3'h7;
         rb_level_r <= 1'b1;
      end else begin
         rb_sync_r <= {rb_sync_r[1:0], ready_busy_n_pin};
         if (rb_sync_r[1] == rb_sync_r[2])
            rb_level_r <= rb_sync_r[2];
      end
   end

   assign device_busy = !rb_level_r;

   //==========================================================================
   // Bus cycle engine
   //==========================================================================
   flash_cycle_if cyc ();

   flash_bus_cycle u_cycle (
      .mclk   (mclk),
      .rstn   (rstn),
      .cyc    (cyc.slave),
      .ce_n   (ce_n),
      .oe_n   (oe_n),
      .we_n   (we_n),
      .dq_out (dq_out),
      .dq_oe  (dq_oe),
      .dq_in  (dq_in)
   );

   //==========================================================================
   // Polling sequencer
   //==========================================================================
   typedef enum logic [2:0] {
      S_IDLE, S_READ1, S_READ2, S_RECHECK, S_FINAL, S_RESET, S_END
   } poll_st_t;

   poll_st_t   st_r, st_nxt;
   logic       meth_r, meth_nxt;
   logic [7:0] exp_r, exp_nxt;
   logic [7:0] prev_r, prev_nxt;
   logic [1:0] res_r, res_nxt;
   logic [7:0] fdata_r, fdata_nxt;
   logic       done_r, done_nxt;
   logic       issued_r, issued_nxt;

   function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
      return a[flash_status_pkg::TOGGLE_ONE_BIT] !=
             b[flash_status_pkg::TOGGLE_ONE_BIT];
   endfunction

   function automatic logic poll_true(input logic [7:0] d, input logic [7:0] e);
      return d[flash_status_pkg::POLL_BIT] == e[flash_status_pkg::POLL_BIT];
   endfunction

   always_comb begin
      st_nxt     = st_r;
      meth_nxt   = meth_r;
      exp_nxt    = exp_r;
      prev_nxt   = prev_r;
      res_nxt    = res_r;
      fdata_nxt  = fdata_r;
      done_nxt   = 1'b0;
      issued_nxt = issued_r;
      cyc.req    = 1'b0;
      cyc.wr     = 1'b0;
      cyc.wdata  = 8'h00;
      if (st_r != S_IDLE && st_r != S_END && !issued_r) begin
         cyc.req    = 1'b1;
         cyc.wr     = (st_r == S_RESET);
         cyc.wdata  = flash_status_pkg::CMD_RESET;
         issued_nxt = 1'b1;
      end
      if (cyc.done)
         issued_nxt = 1'b0;
      unique case (st_r)
         S_IDLE: begin
            if (start) begin
               meth_nxt = method_toggle;
               exp_nxt  = expect_data;
               st_nxt   = S_READ1;
            end
         end
         S_READ1: begin
            if (abort) begin
               res_nxt = flash_status_pkg::RES_ABORTED;
               st_nxt  = S_END;
            end else if (cyc.done) begin
               prev_nxt = cyc.rdata;
               if (meth_r == flash_status_pkg::METHOD_POLL_BIT) begin
                  if (poll_true(cyc.rdata, exp_r))
                     st_nxt = S_FINAL;
                  else if (cyc.rdata[flash_status_pkg::TIMEOUT_BIT])
                     st_nxt = S_RECHECK;
               end else begin
                  st_nxt = S_READ2;
               end
            end
         end
         S_READ2: begin
            if (cyc.done) begin
               if (!toggled(prev_r, cyc.rdata))
                  st_nxt = S_FINAL;
               else if (cyc.rdata[flash_status_pkg::TIMEOUT_BIT]) begin
                  prev_nxt = cyc.rdata;
                  st_nxt   = S_RECHECK;
               end else begin
                  prev_nxt = cyc.rdata;
               end
            end
         end
         S_RECHECK: begin
            if (cyc.done) begin
               if (meth_r == flash_status_pkg::METHOD_POLL_BIT ?
                   poll_true(cyc.rdata, exp_r) :
                   !toggled(prev_r, cyc.rdata))
                  st_nxt = S_FINAL;
               else begin
                  res_nxt = flash_status_pkg::RES_FAIL;
                  st_nxt  = S_RESET;
               end
            end
         end
         S_FINAL: begin
            if (cyc.done) begin
               fdata_nxt = cyc.rdata;
               res_nxt   = flash_status_pkg::RES_DONE;
               st_nxt    = S_END;
            end
         end
         S_RESET: begin
            if (cyc.done)
               st_nxt = S_END;
         end
         S_END: begin
            done_nxt = 1'b1;
            st_nxt   = S_IDLE;
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_r     <= S_IDLE;
         meth_r   <= 1'b0;
         exp_r    <= 8'h00;
         prev_r   <= 8'h00;
         res_r    <= 2'h0;
         fdata_r  <= 8'h00;
         done_r   <= 1'b0;
         issued_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         meth_r   <= meth_nxt;
         exp_r    <= exp_nxt;
         prev_r   <= prev_nxt;
         res_r    <= res_nxt;
         fdata_r  <= fdata_nxt;
         done_r   <= done_nxt;
         issued_r <= issued_nxt;
      end
   end

   assign busy       = (st_r != S_IDLE);
   assign done       = done_r;
   assign result     = res_r;
   assign final_data = fdata_r;

   //==========================================================================
   // Checks
   //==========================================================================
   sequence seq_fail_seen;
      st_r == S_RECHECK && cyc.done && res_nxt == flash_status_pkg::RES_FAIL;
   endsequence

   AST_RESET_AFTER_FAIL: assert property (@(posedge mclk) disable iff (!rstn)
      seq_fail_seen |-> ##[1:20] (!we_n && dq_out == flash_status_pkg::CMD_RESET))
      else $error("no reset write after failure");

   AST_FAIL_NEEDS_RECHECK: assert property (@(posedge mclk) disable iff (!rstn)
      (st_r == S_RESET) |-> $past(st_r) inside {S_RECHECK, S_RESET})
      else $error("failure declared without recheck");

   AST_TOGGLE_TWO_READS: assert property (@(posedge mclk) disable iff (!rstn)
      (st_r == S_READ1 && meth_r && !abort && cyc.done) |=> st_r == S_READ2)
      else $error("toggle check skipped second read");

   AST_FINAL_SEPARATE: assert property (@(posedge mclk) disable iff (!rstn)
      (st_r == S_FINAL && cyc.done) |=> (st_r == S_END && done_r == 1'b0))
      else $error("final data not from own read");

   AST_ABORT_ENDS: assert property (@(posedge mclk) disable iff (!rstn)
      (st_r == S_READ1 && abort) |=> ##1 (done_r &&
       res_r == flash_status_pkg::RES_ABORTED))
      else $error("abort not reported");

   AST_POLL_RECHECK: assert property (@(posedge mclk) disable iff (!rstn)
      (st_r == S_READ1 && !meth_r && !abort && cyc.done &&
       !poll_true(cyc.rdata, exp_r) &&
       cyc.rdata[flash_status_pkg::TIMEOUT_BIT]) |=> st_r == S_RECHECK)
      else $error("polling bit not rechecked");

endmodule : flash_status_poller
`default_nettype wire
